// ==== include/otpp_pkg.sv ====
// constants and types of the one-time PROM programming port
package otpp_pkg;
    localparam int OTPP_ADDR_W = 15;
    localparam int OTPP_DATA_W = 8;
    localparam int OTPP_DEPTH = 32768;
    localparam logic [7:0] OTPP_BLANK = 8'hFF;
    // access mode of the port, decoded from the strobes and the supply level
    typedef enum logic [1:0]
    {
        OTPP_IDLE = 2'b00,
        OTPP_PROG = 2'b01,
        OTPP_VERIFY = 2'b10,
        OTPP_READ = 2'b11
    } otpp_mode_t;
endpackage

// ==== design/otpp_cell_array.sv ====
// 32768 x 8 one-time cell array: programming can only clear bits
module otpp_cell_array
    import otpp_pkg::*;
#(
    parameter int ADDR_W = OTPP_ADDR_W,
    parameter int DATA_W = OTPP_DATA_W
)
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // access
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic prog_i,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic [DATA_W-1:0] rdata_o
);
    logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

    initial
    begin
        for (int i = 0; i < (1 << ADDR_W); i++)
        begin
            cells[i] = OTPP_BLANK[DATA_W-1:0];
        end
    end

    // programmed bits stay programmed; cells keep contents over reset
    always_ff @(posedge core_clk_i)
    begin
        if (prog_i && rst_n_i)
        begin
            cells[addr_i] <= cells[addr_i] & wdata_i;
        end
        rdata_o <= cells[addr_i];
    end
endmodule

// ==== design/otpp_port.sv ====
// programming and readback port of the one-time PROM
import otpp_pkg::*;

// What this block does
// - program mode only when strap a high, strap b low, reset low
// - array holds 32768 bytes at a 15-bit address
// - data pins take write data; drive stored data on verify or read
// - high voltage: ce low oe high programs, ce high oe low verifies
// - logic supply: ce and oe low reads, oe high disables, ce high standby
// - in read mode the addressed byte appears on the data pins
// - ce, oe on port b pins; high address on port f and interrupt pin
module otpp_port
#(
    parameter int ADDR_W = otpp_pkg::OTPP_ADDR_W,
    parameter int DATA_W = otpp_pkg::OTPP_DATA_W
)
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // mode straps and device reset pin
    input wire logic strap_select_a_i,
    input wire logic strap_select_b_i,
    input wire logic dev_reset_n_i,
    // program supply at high voltage (1) or logic level (0)
    input wire logic vpp_high_i,
    // strobes, received on port b pins
    input wire logic chip_enable_n_i,
    input wire logic output_enable_n_i,
    // address: low byte on port a, a8 and a14..a10 on port f, a9 on nmi
    input wire logic [7:0] port_a_addr_i,
    input wire logic [7:0] port_f_addr_i,
    input wire logic nmi_addr_i,
    // data pins, three signals each
    input wire logic [DATA_W-1:0] prom_data_io_i,
    output logic [DATA_W-1:0] prom_data_io_o,
    output logic [DATA_W-1:0] prom_data_io_oe_n_o,
    // status
    output logic prog_mode_o,
    output logic [1:0] port_mode_o
);
    import otpp_pkg::*;

    initial
    begin
        if (ADDR_W != 15 || DATA_W != 8)
        begin
            $error("otpp_port supports only 15-bit address, 8-bit data");
        end
    end

    logic [ADDR_W-1:0] prom_address_in;
    logic in_prog;
    otpp_mode_t mode, next_mode;
    logic next_prog_mode;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] data_q, next_data_q;
    logic [DATA_W-1:0] oe_n_q, next_oe_n_q;
    logic cell_prog;

    // address bits collected from alternate pins
    assign prom_address_in = {port_f_addr_i[6:2], nmi_addr_i,
                              port_f_addr_i[0], port_a_addr_i};
    assign in_prog = strap_select_a_i && !strap_select_b_i && !dev_reset_n_i;

    // decode of strobes and supply level, and
    always_comb
    begin
        next_mode = OTPP_IDLE;
        if (in_prog)
        begin
            if (vpp_high_i)
            begin
                if (!chip_enable_n_i && output_enable_n_i)
                begin
                    next_mode = OTPP_PROG;
                end
                else if (chip_enable_n_i && !output_enable_n_i)
                begin
                    next_mode = OTPP_VERIFY;
                end
                else
                begin
                    next_mode = OTPP_IDLE; // inhibit
                end
            end
            else if (!chip_enable_n_i && !output_enable_n_i)
            begin
                next_mode = OTPP_READ;
            end
        end
    end

    // program the addressed byte while the pulse lasts
    assign cell_prog = (mode == OTPP_PROG) && (next_mode == OTPP_PROG);

    otpp_cell_array #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W)
    ) u_cells (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .addr_i(prom_address_in),
        .prog_i(cell_prog),
        .wdata_i(prom_data_io_i),
        .rdata_o(rdata)
    );

    // output drivers: enabled on verify and read, and
    always_comb
    begin
        next_prog_mode = in_prog;
        next_data_q = '0;
        next_oe_n_q = {DATA_W{1'b1}};
        case (mode)
            OTPP_VERIFY, OTPP_READ:
            begin
                next_data_q = rdata;
                next_oe_n_q = '0;
            end
            default:
            begin
                next_data_q = '0;
                next_oe_n_q = {DATA_W{1'b1}};
            end
        endcase
        if (next_mode != mode)
        begin
            next_oe_n_q = {DATA_W{1'b1}};
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            mode <= OTPP_IDLE;
            prog_mode_o <= 1'b0;
            data_q <= '0;
            oe_n_q <= {DATA_W{1'b1}};
        end
        else
        begin
            mode <= next_mode;
            prog_mode_o <= next_prog_mode;
            data_q <= next_data_q;
            oe_n_q <= next_oe_n_q;
        end
    end

    assign prom_data_io_o = data_q;
    assign prom_data_io_oe_n_o = oe_n_q;
    assign port_mode_o = mode;

    // assertions
    sequence s_read_held;
        (mode == OTPP_READ) ##1 (mode == OTPP_READ);
    endsequence

    AST_NO_PROG_OUTSIDE_MODE: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) !in_prog |=> (mode == OTPP_IDLE))
        else $error("access decoded outside programming mode");
    AST_PROG_DECODE: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (in_prog && vpp_high_i && !chip_enable_n_i && output_enable_n_i)
        |=> (mode == OTPP_PROG))
        else $error("program strobes not decoded as program");
    AST_VERIFY_DRIVES: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (mode == OTPP_VERIFY) ##1 (mode == OTPP_VERIFY)
        |-> (prom_data_io_oe_n_o == '0))
        else $error("verify does not drive the data pins");
    AST_READ_DATA: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        s_read_held |-> (prom_data_io_o == $past(rdata)))
        else $error("read data does not match the array");
    AST_PROG_FLOAT: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (mode == OTPP_PROG) |=> (prom_data_io_oe_n_o == {DATA_W{1'b1}}))
        else $error("data pins driven while programming");
    AST_STANDBY: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (in_prog && !vpp_high_i && chip_enable_n_i) |=> (mode == OTPP_IDLE))
        else $error("standby not honoured");
    AST_BOTH_LOW_HV: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (vpp_high_i && !chip_enable_n_i && !output_enable_n_i)
        |=> (mode == OTPP_IDLE) ##1 prom_data_io_oe_n_o[0])
        else $error("forbidden strobe pair not inhibited");
    // the first edge after reset release still shows the reset value
    AST_MODE_FLAG: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        $past(rst_n_i) |-> (prog_mode_o == $past(in_prog)))
        else $error("programming mode flag wrong");
endmodule

// ==== verification/otpp_programmer.sv ====
// programmer model driving the port pins and running the write loop
module otpp_programmer
#(
    parameter int PULSE = 4
)
(
    // clock
    input wire logic core_clk_i,
    // read back from the port
    input wire logic [7:0] rd_i,
    input wire logic [7:0] oen_i,
    // pins toward the port
    output logic sa_o,
    output logic sb_o,
    output logic rst_n_o,
    output logic vpp_o,
    output logic ce_n_o,
    output logic oe_n_o,
    output logic [7:0] pa_o,
    output logic [7:0] pf_o,
    output logic nmi_o,
    output logic [7:0] wd_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import otpp_pkg::*;
    initial
    begin
        {sa_o, sb_o, rst_n_o, vpp_o, ce_n_o, oe_n_o} = 6'h23;
        {pa_o, pf_o, nmi_o, wd_o} = 25'h0;
    end
    task automatic straps(input logic a, input logic b, input logic r);
        @(posedge core_clk_i);
        #1;
        {sa_o, sb_o, rst_n_o} = {a, b, r};
    endtask
    task automatic drive(input logic v, input logic c, input logic o,
        input int n);
        @(posedge core_clk_i);
        #1;
        vpp_o = v;
        ce_n_o = c;
        oe_n_o = o;
        if (!o)
            wd_o = ~wd_o; // data inverted while the port may drive
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    // only called with chip enable high
    task automatic put(input logic [14:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        #1;
        pa_o = a[7:0];
        pf_o = {1'b0, a[14:10], 1'b0, a[8]};
        nmi_o = a[9];
        wd_o = d;
    endtask
    task automatic write_byte(input logic [14:0] a, input logic [7:0] d,
        output logic ok, output int tries);
        ok = 1'b0;
        tries = 0;
        drive(1'b1, 1'b1, 1'b1, 1);
        while (!ok && tries < 25)
        begin
            put(a, d);
            drive(1'b1, 1'b0, 1'b1, PULSE);
            drive(1'b1, 1'b1, 1'b0, 2);
            ok = (oen_i === 8'h00) && (rd_i === d);
            drive(1'b1, 1'b1, 1'b1, 1);
            tries++;
        end
        if (ok)
        begin
            put(a, d);
            drive(1'b1, 1'b0, 1'b1, 3 * PULSE * tries);
            drive(1'b1, 1'b1, 1'b1, 1);
        end
    endtask
endmodule

// ==== verification/otpp_port_test.sv ====
// self-checking bench of the one-time PROM programming port
module otpp_port_test;
    timeunit 1ns;
    timeprecision 100ps;
    import otpp_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sa, sb, rn, vpp, ce_n, oe_n, nmi, pm, ok;
    logic [7:0] pa, pf, wd, rd, oen;
    logic [1:0] md;
    int miscompares = 0;
    int compares = 0;
    int n;
    always #2 core_clk_i = ~core_clk_i;
    otpp_programmer u_prog (.core_clk_i(core_clk_i), .rd_i(rd),
        .oen_i(oen), .sa_o(sa), .sb_o(sb), .rst_n_o(rn), .vpp_o(vpp),
        .ce_n_o(ce_n), .oe_n_o(oe_n), .pa_o(pa), .pf_o(pf), .nmi_o(nmi),
        .wd_o(wd));
    otpp_port u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .strap_select_a_i(sa), .strap_select_b_i(sb), .dev_reset_n_i(rn),
        .vpp_high_i(vpp), .chip_enable_n_i(ce_n), .output_enable_n_i(oe_n),
        .port_a_addr_i(pa), .port_f_addr_i(pf), .nmi_addr_i(nmi),
        .prom_data_io_i(wd), .prom_data_io_o(rd), .prom_data_io_oe_n_o(oen),
        .prog_mode_o(pm), .port_mode_o(md));
    task automatic chk(input string nm, input logic [7:0] seen,
        input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rdchk(input logic [14:0] a, input logic [7:0] exp);
        u_prog.put(a, 8'h00);
        u_prog.drive(1'b0, 1'b0, 1'b0, 2);
        chk("rdata", rd, exp);
        chk("oe_n", oen, 8'h00);
        chk("mode", {6'h0, md}, 8'h03);
        u_prog.drive(1'b0, 1'b1, 1'b1, 1);
    endtask
    task automatic t_write();
        u_prog.write_byte(15'h72A5, 8'h3C, ok, n);
        chk("prog", {7'h0, pm}, 8'h01);
        chk("ok", {7'h0, ok}, 8'h01);
        chk("tries", n[7:0], 8'h01);
        rdchk(15'h72A5, 8'h3C);
        rdchk(15'h52A5, 8'hFF);
        rdchk(15'h70A5, 8'hFF);
        rdchk(15'h73A5, 8'hFF);
    endtask
    task automatic t_refuse();
        u_prog.write_byte(15'h72A5, 8'hC3, ok, n);
        chk("ok", {7'h0, ok}, 8'h00);
        chk("tries", n[7:0], 8'h19);
        rdchk(15'h72A5, 8'h00);
    endtask
    task automatic t_modes();
        logic [2:0] v [5] = '{3'h4, 3'h7, 3'h1, 3'h2, 3'h3};
        for (int i = 0; i < 5; i++)
        begin
            u_prog.drive(v[i][2], v[i][1], v[i][0], 2);
            chk("oe_n", oen, 8'hFF);
            chk("mode", {6'h0, md}, 8'h00);
        end
        u_prog.straps(1'b1, 1'b1, 1'b0);
        u_prog.drive(1'b0, 1'b0, 1'b0, 2);
        chk("prog", {7'h0, pm}, 8'h00);
        chk("oe_n", oen, 8'hFF);
        u_prog.straps(1'b1, 1'b0, 1'b1);
        u_prog.drive(1'b0, 1'b0, 1'b0, 2);
        chk("prog", {7'h0, pm}, 8'h00);
    endtask
    task automatic final_report();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge core_clk_i);
        #1;
        chk("oe_n", oen, 8'hFF);
        chk("prog", {7'h0, pm}, 8'h00);
        rst_n_i = 1'b1;
        t_write();
        t_refuse();
        t_modes();
        final_report();
    end
    initial
    begin
        #40000;
        miscompares++;
        final_report();
    end
endmodule
